// file: design/fifo_mem.sv
// Byte memory of the physical FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none

module fifo_mem (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       enable,
    input  wire logic       wr_en,
    input  wire logic [5:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_en,
    input  wire logic [5:0] rd_addr,
    output logic      [7:0] rd_data
);
    rf_fifo_pkg::mem_state_t st;
    rf_fifo_pkg::mem_state_t next_st;

    always_comb begin
        next_st = st;
        if (wr_en) begin
            next_st.cells[wr_addr] = wr_data;
        end
        if (rd_en) begin
            next_st.rdata = st.cells[rd_addr];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else if (enable) begin
            st <= next_st;
        end
    end

    assign rd_data = st.rdata;
endmodule

`default_nettype wire

// file: design/rf_fifo_consts.svh
// Constants for the packet FIFO and link controller
`ifndef RF_FIFO_CONSTS_SVH
`define RF_FIFO_CONSTS_SVH

`define FIFO_DEPTH      7'h40
`define PTR_RESET       7'h00
`define PTR_STEP        7'h01
`define MODE_SIMPLE     2'h0
`define MODE_BLOCK      2'h1
`define MODE_EXTEND     2'h2
`define MARGIN_4        7'h04
`define MARGIN_8        7'h08
`define MARGIN_16       7'h10
`define MARGIN_32       7'h20
`define GIO_SEL_IRQ     3'h5
`define SEQ_ID_MSB      7
`define SEQ_ID_LSB      6
`define ARK_UNIT_NS     250000
`define CLOCK_PERIOD_NS 8
`define TICK_RESET      16'h0000
`define TICK_STEP       16'h0001
`define WAIT_RESET      9'h000
`define WAIT_STEP       9'h001
`define RESEND_RESET    5'h00
`define RESEND_STEP     5'h01
`define LEN_STEP        8'h01

`endif

// file: design/rf_fifo_pkg.sv
// Types shared by the packet FIFO and link controller
package rf_fifo_pkg;

    typedef enum logic [2:0] {
        ST_SLEEP,
        ST_TX,
        ST_LISTEN,
        ST_RX,
        ST_GAP,
        ST_ACK_TX
    } link_state_t;

    typedef struct packed {
        logic [1:0]      fifo_mode;
        logic            endless_mode_en;
        logic [5:0]      tx_start_addr;
        logic [7:0]      tx_length;
        logic            margin_detect_en;
        logic [1:0]      fifo_margin_sel;
        logic            low_level_irq_en;
        logic [2:0][2:0] pin_func_sel;
        logic            repeat_rx_en;
        logic [2:0]      rx_restart_delay;
        logic            len_to_fifo_en;
        logic            length_field_en;
        logic            resend_ack_en;
        logic [3:0]      resend_limit;
        logic [7:0]      ack_wait_period;
    } link_cfg_t;

    typedef struct packed {
        logic        byte_valid;
        logic [7:0]  byte_data;
        logic        byte_is_hdr;
        logic        byte_is_len;
        logic        pkt_start;
        logic        pkt_done;
        logic        pkt_ok;
        logic [15:0] crc;
        logic        ack_tx_done;
    } radio_in_t;

    typedef struct packed {
        logic tx_done;
        logic tx_fail;
        logic tx_abort;
        logic rx_done;
        logic rx_error;
    } link_event_t;

    typedef struct packed {
        logic [1:0][7:0] data;
        logic [1:0]      count;
    } skid_state_t;

    typedef struct packed {
        logic [63:0][7:0] cells;
        logic [7:0]       rdata;
    } mem_state_t;

endpackage

// file: design/rf_packet_fifo_link_control.sv
// Packet FIFO and link-layer controller of the RF transceiver
//
// Summary of operation
// - Separate TX and RX pointer resets return pointers and buffer to reset state.
// - Simple mode: up to 64 bytes, sent in write order, MSB first.
// - Simple-mode data stays stored; each transmission restarts the read pointer at zero.
// - Block mode sends the given length from the chosen start address.
// - Extend mode streams up to 255 bytes through the 64-byte FIFO.
// - Margin detect, in extend or endless streaming only, sets the low-level flag when TX fill drops below the threshold or RX free space falls to it.
// - An emptied FIFO during extend or infinite packets ends the transmission.
// - Selector code 101b routes the interrupt request onto that pin.
// - Endless mode streams; clearing it plus a length finishes the packet.
// - Repeat receive flags valid packets, restarts after the restart delay.
// - Sleep strobe stops repeated receive; use it with simple mode only.
// - Length byte may be stored in the FIFO, leaving 63 data bytes.
// - In repeat receive, a new packet over unread data sets the error flag and interrupt.
// - Resend/ack enable: transmit strobe resends, receive strobe acknowledges.
// - Simple mode: listen ack_wait_period+1 units after sending; valid ack completes.
// - No ack: resend same data until count reaches resend_limit plus one.
// - Sequence id and checksum equal to the last packet mark a repeat.
// - New good packet: interrupt and ack; repeat: ack only.
// - Failed checksum or address: no interrupt, reception restarts.
// - Wait ack_wait_period after a receive before restarting reception.
// - Sequence id sits in bits 7:6 of the first header byte.
// - Length field copies tx_length when length_field_en is set.
`timescale 1ns/1ps
`default_nettype none
`include "rf_fifo_consts.svh"

module rf_packet_fifo_link_control #(
    parameter int unsigned TICK_CYCLES = `ARK_UNIT_NS / `CLOCK_PERIOD_NS
) (
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    input  wire logic                    enable,
    input  wire rf_fifo_pkg::link_cfg_t  cfg,
    input  wire logic                    tx_ptr_reset,
    input  wire logic                    rx_ptr_reset,
    input  wire logic                    tx_strobe,
    input  wire logic                    rx_strobe,
    input  wire logic                    sleep_strobe,
    input  wire logic                    low_level_clear,
    input  wire logic                    host_wr_valid,
    input  wire logic [7:0]              host_wr_data,
    output logic                         host_wr_ready,
    input  wire logic                    host_rd_req,
    output logic                         host_rd_valid,
    output logic [7:0]                   host_rd_data,
    input  wire rf_fifo_pkg::radio_in_t  radio,
    output logic                         tx_byte_valid,
    output logic [7:0]                   tx_byte,
    input  wire logic                    tx_byte_ready,
    output logic                         tx_active,
    output logic                         rx_active,
    output logic                         ack_req,
    output logic [7:0]                   length_field,
    output logic [6:0]                   tx_read_ptr,
    output logic [4:0]                   resend_count,
    output logic                         low_level_flag,
    output logic                         rx_error_flag,
    output rf_fifo_pkg::link_event_t     events,
    output logic [2:0]                   gio,
    output rf_fifo_pkg::link_state_t     link_state
);
    typedef struct packed {
        rf_fifo_pkg::link_state_t  state;
        logic [6:0]                tx_wr;
        logic [6:0]                tx_rd;
        logic [7:0]                tx_left;
        logic                      rd_pend;
        logic                      host_pend;
        logic [6:0]                rx_wr;
        logic [6:0]                rx_rd;
        logic [4:0]                resend_cnt;
        logic [15:0]               tick_cnt;
        logic [8:0]                wait_cnt;
        logic                      low_level_flag;
        logic                      rx_error_flag;
        logic [1:0]                cur_id;
        logic [1:0]                prev_id;
        logic [15:0]               prev_crc;
        logic                      prev_valid;
        logic                      endless_prev;
        logic                      ring_tx;
        logic [7:0]                length_field;
        rf_fifo_pkg::link_event_t  events;
        logic                      ack_req;
        logic [2:0]                gio;
    } ctrl_state_t;

    ctrl_state_t st;
    ctrl_state_t next_st;

    logic       mem_wr_en;
    logic [5:0] mem_wr_addr;
    logic [7:0] mem_wr_data;
    logic       mem_rd_en;
    logic [5:0] mem_rd_addr;
    logic [7:0] mem_rd_data;
    logic       buf_in_ready;
    logic       buf_flush;
    logic       streaming;
    logic [6:0] tx_fill;
    logic [6:0] rx_fill;
    logic       irq;

    function automatic logic [6:0] margin(input logic [1:0] sel);
        case (sel)
            2'h0:    margin = `MARGIN_4;
            2'h1:    margin = `MARGIN_8;
            2'h2:    margin = `MARGIN_16;
            default: margin = `MARGIN_32;
        endcase
    endfunction

    // Simple mode restarts at offset zero, block at its start address
    function automatic ctrl_state_t begin_tx(input ctrl_state_t s, input rf_fifo_pkg::link_cfg_t c);
        begin_tx = s;
        begin_tx.state = rf_fifo_pkg::ST_TX;
        begin_tx.tx_left = c.tx_length;
        if (!c.endless_mode_en && c.fifo_mode != `MODE_EXTEND) begin
            begin_tx.tx_rd = `PTR_RESET;
        end
    endfunction

    function automatic ctrl_state_t begin_wait(input ctrl_state_t s, input rf_fifo_pkg::link_state_t n,
                                               input logic [8:0] ticks);
        begin_wait = s;
        begin_wait.state = n;
        begin_wait.wait_cnt = ticks;
        begin_wait.tick_cnt = `TICK_RESET;
    endfunction

    // Extend and infinite modes consume the FIFO as a ring
    assign streaming = (cfg.fifo_mode == `MODE_EXTEND) || cfg.endless_mode_en || st.ring_tx;
    assign tx_fill   = st.tx_wr - st.tx_rd;
    assign rx_fill   = st.rx_wr - st.rx_rd;
    assign buf_flush = sleep_strobe || tx_ptr_reset;

    assign host_wr_ready = (st.state != rf_fifo_pkg::ST_RX) &&
                           (streaming ? (tx_fill != `FIFO_DEPTH) : !st.tx_wr[6]);

    always_comb begin
        next_st = st;
        next_st.events = '0;
        next_st.ack_req = 1'b0;
        next_st.rd_pend = 1'b0;
        next_st.host_pend = 1'b0;
        mem_wr_en = 1'b0;
        mem_wr_addr = st.tx_wr[5:0];
        mem_wr_data = host_wr_data;
        mem_rd_en = 1'b0;
        mem_rd_addr = st.rx_rd[5:0];

        next_st.length_field = cfg.length_field_en ? cfg.tx_length : 8'h00;
        next_st.endless_prev = cfg.endless_mode_en;

        // Host side FIFO access; radio bytes own the write port while receiving
        if (host_wr_valid && host_wr_ready) begin
            mem_wr_en = 1'b1;
            next_st.tx_wr = st.tx_wr + `PTR_STEP;
        end
        if (host_rd_req && st.state != rf_fifo_pkg::ST_TX && rx_fill != `PTR_RESET) begin
            mem_rd_en = 1'b1;
            next_st.host_pend = 1'b1;
            next_st.rx_rd = st.rx_rd + `PTR_STEP;
        end

        // Remaining length taken over when endless streaming is switched off
        if (st.endless_prev && !cfg.endless_mode_en) begin
            next_st.tx_left = cfg.tx_length;
        end

        if (st.state == rf_fifo_pkg::ST_LISTEN || st.state == rf_fifo_pkg::ST_GAP) begin
            if (st.tick_cnt == 16'(TICK_CYCLES - 1)) begin
                next_st.tick_cnt = `TICK_RESET;
                if (st.wait_cnt != `WAIT_RESET) begin
                    next_st.wait_cnt = st.wait_cnt - `WAIT_STEP;
                end
            end else begin
                next_st.tick_cnt = st.tick_cnt + `TICK_STEP;
            end
        end

        case (st.state)
            rf_fifo_pkg::ST_SLEEP: begin
                if (tx_strobe) begin
                    next_st = begin_tx(next_st, cfg);
                    next_st.resend_cnt = `RESEND_RESET;
                end else if (rx_strobe) begin
                    next_st.state = rf_fifo_pkg::ST_RX;
                end
            end
            rf_fifo_pkg::ST_TX: begin
                if (st.tx_left != 8'h00 && buf_in_ready && !st.rd_pend &&
                    (!streaming || tx_fill != `PTR_RESET)) begin
                    mem_rd_en = 1'b1;
                    mem_rd_addr = streaming ? st.tx_rd[5:0] : cfg.tx_start_addr + st.tx_rd[5:0];
                    next_st.rd_pend = 1'b1;
                    next_st.tx_rd = st.tx_rd + `PTR_STEP;
                    if (!cfg.endless_mode_en) begin
                        next_st.tx_left = st.tx_left - `LEN_STEP;
                    end
                end else if (!st.rd_pend && !tx_byte_valid) begin
                    if (st.tx_left == 8'h00) begin
                        if (cfg.resend_ack_en && cfg.fifo_mode == `MODE_SIMPLE) begin
                            next_st = begin_wait(next_st, rf_fifo_pkg::ST_LISTEN,
                                                 {1'b0, cfg.ack_wait_period} + `WAIT_STEP);
                        end else begin
                            next_st.state = rf_fifo_pkg::ST_SLEEP;
                            next_st.events.tx_done = 1'b1;
                        end
                    end else if (streaming && tx_fill == `PTR_RESET) begin
                        // Starved ring: the packet cannot be completed
                        next_st.state = rf_fifo_pkg::ST_SLEEP;
                        next_st.events.tx_abort = 1'b1;
                    end
                end
            end
            rf_fifo_pkg::ST_LISTEN: begin
                if (radio.pkt_done && radio.pkt_ok) begin
                    next_st.state = rf_fifo_pkg::ST_SLEEP;
                    next_st.events.tx_done = 1'b1;
                end else if (st.wait_cnt == `WAIT_RESET) begin
                    if (st.resend_cnt == {1'b0, cfg.resend_limit} + `RESEND_STEP) begin
                        next_st.state = rf_fifo_pkg::ST_SLEEP;
                        next_st.events.tx_fail = 1'b1;
                    end else begin
                        next_st = begin_tx(next_st, cfg);
                        next_st.resend_cnt = st.resend_cnt + `RESEND_STEP;
                    end
                end
            end
            rf_fifo_pkg::ST_RX: begin
                if (radio.byte_valid && !(radio.byte_is_len && !cfg.len_to_fifo_en)) begin
                    mem_wr_en = 1'b1;
                    mem_wr_addr = st.rx_wr[5:0];
                    mem_wr_data = radio.byte_data;
                    next_st.rx_wr = st.rx_wr + `PTR_STEP;
                end
                if (radio.byte_valid && radio.byte_is_hdr) begin
                    next_st.cur_id = radio.byte_data[`SEQ_ID_MSB:`SEQ_ID_LSB];
                end
                if (radio.pkt_done) begin
                    if (cfg.resend_ack_en) begin
                        if (radio.pkt_ok) begin
                            // Repeat when id and checksum both match the last good packet
                            if (!(st.prev_valid && st.prev_id == st.cur_id && st.prev_crc == radio.crc)) begin
                                next_st.events.rx_done = 1'b1;
                            end
                            next_st.prev_valid = 1'b1;
                            next_st.prev_id = st.cur_id;
                            next_st.prev_crc = radio.crc;
                            next_st.ack_req = 1'b1;
                            next_st.state = rf_fifo_pkg::ST_ACK_TX;
                        end
                    end else if (cfg.repeat_rx_en) begin
                        next_st.events.rx_done = radio.pkt_ok;
                        next_st = begin_wait(next_st, rf_fifo_pkg::ST_GAP, {6'h00, cfg.rx_restart_delay});
                    end else begin
                        next_st.events.rx_done = radio.pkt_ok;
                        next_st.state = rf_fifo_pkg::ST_SLEEP;
                    end
                end
            end
            rf_fifo_pkg::ST_ACK_TX: begin
                if (radio.ack_tx_done) begin
                    next_st = begin_wait(next_st, rf_fifo_pkg::ST_GAP, {1'b0, cfg.ack_wait_period});
                end
            end
            rf_fifo_pkg::ST_GAP: begin
                if (st.wait_cnt == `WAIT_RESET) begin
                    next_st.state = rf_fifo_pkg::ST_RX;
                end
            end
            default: next_st.state = rf_fifo_pkg::ST_SLEEP;
        endcase

        if (sleep_strobe) begin
            next_st.state = rf_fifo_pkg::ST_SLEEP;
            next_st.rd_pend = 1'b0;
        end
        next_st.ring_tx = streaming && next_st.state == rf_fifo_pkg::ST_TX;

        // Pointer resets first, so any flag set below still wins
        if (tx_ptr_reset) begin
            next_st.tx_wr = `PTR_RESET;
            next_st.tx_rd = `PTR_RESET;
            next_st.rd_pend = 1'b0;
            next_st.low_level_flag = 1'b0;
        end
        if (rx_ptr_reset) begin
            next_st.rx_wr = `PTR_RESET;
            next_st.rx_rd = `PTR_RESET;
            next_st.rx_error_flag = 1'b0;
        end
        if (low_level_clear) begin
            next_st.low_level_flag = 1'b0;
        end
        if (cfg.margin_detect_en && streaming &&
            ((st.state == rf_fifo_pkg::ST_TX && tx_fill < margin(cfg.fifo_margin_sel)) ||
             (st.state == rf_fifo_pkg::ST_RX && rx_fill >= `FIFO_DEPTH - margin(cfg.fifo_margin_sel)))) begin
            next_st.low_level_flag = 1'b1;
        end
        // Unread data still present when the next packet begins
        if (st.state == rf_fifo_pkg::ST_RX && radio.pkt_start && cfg.repeat_rx_en && rx_fill != `PTR_RESET) begin
            next_st.rx_error_flag = 1'b1;
            next_st.events.rx_error = 1'b1;
        end

        irq = (next_st.low_level_flag && cfg.low_level_irq_en) || (next_st.events != '0);
        for (int i = 0; i < 3; i++) begin
            next_st.gio[i] = (cfg.pin_func_sel[i] == `GIO_SEL_IRQ) && irq;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else if (enable) begin
            st <= next_st;
        end
    end

    fifo_mem mem (
        .clock   (clock),
        .rst_b   (rst_b),
        .enable  (enable),
        .wr_en   (mem_wr_en),
        .wr_addr (mem_wr_addr),
        .wr_data (mem_wr_data),
        .rd_en   (mem_rd_en),
        .rd_addr (mem_rd_addr),
        .rd_data (mem_rd_data)
    );

    // Stall by the modulator holds reads back instead of dropping bytes
    skid_buffer out_buf (
        .clock     (clock),
        .rst_b     (rst_b),
        .enable    (enable),
        .flush     (buf_flush),
        .in_valid  (st.rd_pend),
        .in_data   (mem_rd_data),
        .in_ready  (buf_in_ready),
        .out_valid (tx_byte_valid),
        .out_data  (tx_byte),
        .out_ready (tx_byte_ready)
    );

    assign host_rd_valid  = st.host_pend;
    assign host_rd_data   = mem_rd_data;
    assign tx_active      = (st.state == rf_fifo_pkg::ST_TX);
    assign rx_active      = (st.state == rf_fifo_pkg::ST_RX) || (st.state == rf_fifo_pkg::ST_LISTEN);
    assign ack_req        = st.ack_req;
    assign length_field   = st.length_field;
    assign tx_read_ptr    = st.tx_rd;
    assign resend_count   = st.resend_cnt;
    assign low_level_flag = st.low_level_flag;
    assign rx_error_flag  = st.rx_error_flag;
    assign events         = st.events;
    assign gio            = st.gio;
    assign link_state     = st.state;
endmodule

`default_nettype wire

// file: design/skid_buffer.sv
// Two-entry byte buffer between FIFO read and the modulator
`timescale 1ns/1ps
`default_nettype none

module skid_buffer (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       enable,
    input  wire logic       flush,
    input  wire logic       in_valid,
    input  wire logic [7:0] in_data,
    output logic            in_ready,
    output logic            out_valid,
    output logic      [7:0] out_data,
    input  wire logic       out_ready
);
    rf_fifo_pkg::skid_state_t st;
    rf_fifo_pkg::skid_state_t next_st;
    logic                     push;
    logic                     pop;

    assign in_ready  = (st.count != 2'h2);
    assign out_valid = (st.count != 2'h0);
    assign out_data  = st.data[0];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (pop) begin
            next_st.data[0] = st.data[1];
        end
        if (push) begin
            // Entry slot depends on whether the head leaves this cycle
            if (st.count == 2'h0 || (st.count == 2'h1 && pop)) begin
                next_st.data[0] = in_data;
            end else begin
                next_st.data[1] = in_data;
            end
        end
        next_st.count = st.count + {1'b0, push} - {1'b0, pop};
        if (flush) begin
            next_st.count = 2'h0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else if (enable) begin
            st <= next_st;
        end
    end
endmodule

`default_nettype wire

// file: tb/modulator_model.sv
// Modulator stand-in that stalls the byte stream and logs bytes
`timescale 1ns/1ps
`default_nettype none
module modulator_model (
    input  wire logic       clock,
    input  wire logic       tx_byte_valid,
    input  wire logic [7:0] tx_byte,
    output var  logic       tx_byte_ready
);
    logic [1:0] phase = 2'h0;
    logic [7:0] seen[$];
    // Stall one cycle in three so the buffer must hold a word
    always @(posedge clock) begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        tx_byte_ready <= (phase != 2'h2);
        if (tx_byte_valid && tx_byte_ready) begin
            seen.push_back(tx_byte);
        end
    end
endmodule
`default_nettype wire

// file: tb/rf_link_properties.sv
// Port timing checks for the packet FIFO link controller
`timescale 1ns/1ps
`default_nettype none
module rf_link_properties (
    input wire logic                     clock,
    input wire logic                     rst_b,
    input wire logic                     enable,
    input wire rf_fifo_pkg::link_cfg_t   cfg,
    input wire logic                     tx_ptr_reset,
    input wire logic                     rx_ptr_reset,
    input wire logic                     tx_strobe,
    input wire logic                     sleep_strobe,
    input wire logic                     host_rd_req,
    input wire logic                     host_rd_valid,
    input wire logic                     tx_byte_valid,
    input wire logic [7:0]               tx_byte,
    input wire logic                     tx_byte_ready,
    input wire logic [7:0]               length_field,
    input wire logic [6:0]               tx_read_ptr,
    input wire logic                     rx_error_flag,
    input wire rf_fifo_pkg::link_event_t events,
    input wire logic [2:0]               gio,
    input wire rf_fifo_pkg::link_state_t link_state
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b || !enable);
    a_read_answer: assert property (host_rd_valid |-> $past(host_rd_req)) else $error("read answer late");
    a_len_copy: assert property (cfg.length_field_en |=> length_field == $past(cfg.tx_length))
        else $error("length field not copied");
    a_ptr_home: assert property (tx_ptr_reset |=> tx_read_ptr == 7'h00) else $error("pointer not home");
    a_flag_clear: assert property (rx_ptr_reset |=> !rx_error_flag || events.rx_error)
        else $error("error flag kept");
    a_sleep_wins: assert property (sleep_strobe |=> link_state == rf_fifo_pkg::ST_SLEEP)
        else $error("sleep not entered");
    a_tx_launch: assert property (tx_strobe && !sleep_strobe && link_state == rf_fifo_pkg::ST_SLEEP
        && cfg.tx_length != 8'h00 |-> ##[1:3] (tx_byte_valid || events.tx_abort || sleep_strobe || tx_ptr_reset))
        else $error("no first byte");
    a_byte_hold: assert property (tx_byte_valid && !tx_byte_ready && !sleep_strobe && !tx_ptr_reset
        |=> tx_byte_valid && $stable(tx_byte)) else $error("byte dropped in stall");
    a_done_single: assert property (events.tx_done |=> !events.tx_done) else $error("done held");
    a_gio_quiet: assert property (cfg.pin_func_sel[1] != 3'h5 [*2] |-> gio[1] == 1'b0)
        else $error("pin driven unselected");
endmodule
bind rf_packet_fifo_link_control rf_link_properties u_props (.clock, .rst_b, .enable, .cfg, .tx_ptr_reset,
    .rx_ptr_reset, .tx_strobe, .sleep_strobe, .host_rd_req, .host_rd_valid, .tx_byte_valid, .tx_byte,
    .tx_byte_ready, .length_field, .tx_read_ptr, .rx_error_flag, .events, .gio, .link_state);
`default_nettype wire

// file: tb/rf_packet_fifo_link_control_bench.sv
// Self-checking bench for the packet FIFO link controller
`timescale 1ns/1ps
`default_nettype none
`include "rf_fifo_consts.svh"
module rf_packet_fifo_link_control_bench;
    logic                     clock = 1'b0;
    logic                     rst_b = 1'b0;
    rf_fifo_pkg::link_cfg_t   cfg = '0;
    logic [4:0]               cmd = 5'h00;
    logic                     host_wr_valid = 1'b0;
    logic [7:0]               host_wr_data = 8'h00;
    logic                     host_wr_ready, tx_byte_valid, tx_byte_ready;
    logic [7:0]               tx_byte, length_field;
    logic [4:0]               resend_count;
    rf_fifo_pkg::link_event_t events;
    int                       n_errors = 0;
    int                       n_compared = 0;
    logic [7:0]               pat [4] = '{8'hA5, 8'h3C, 8'h0F, 8'hF0};
    always #4 clock = ~clock;
    rf_packet_fifo_link_control #(.TICK_CYCLES(4)) u_dut (.clock, .rst_b, .enable(1'b1), .cfg,
        .tx_ptr_reset(cmd[0]), .rx_ptr_reset(cmd[1]), .tx_strobe(cmd[2]), .rx_strobe(cmd[3]),
        .sleep_strobe(cmd[4]), .low_level_clear(1'b0), .host_wr_valid, .host_wr_data, .host_wr_ready,
        .host_rd_req(1'b0), .host_rd_valid(), .host_rd_data(), .radio('0), .tx_byte_valid, .tx_byte,
        .tx_byte_ready, .tx_active(), .rx_active(), .ack_req(), .length_field, .tx_read_ptr(),
        .resend_count, .low_level_flag(), .rx_error_flag(), .events, .gio(), .link_state());
    modulator_model u_mod (.clock, .tx_byte_valid, .tx_byte, .tx_byte_ready);
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task pulse(input int b);
        @(posedge clock);
        cmd <= 5'h01 << b;
        @(posedge clock);
        cmd <= 5'h00;
    endtask
    task write_byte(input logic [7:0] d);
        @(posedge clock);
        host_wr_valid <= 1'b1;
        host_wr_data <= d;
        do @(negedge clock); while (host_wr_ready !== 1'b1);
        @(posedge clock);
        host_wr_valid <= 1'b0;
    endtask
    // Strobe a send, wait for its closing event, then compare the stream
    task send(input int first, input int n, input int reps, input bit fail);
        int i;
        u_mod.seen.delete();
        pulse(2);
        for (i = 0; i < 4000; i++) begin
            @(posedge clock);
            #1;
            if ((fail ? events.tx_fail : events.tx_done) === 1'b1) break;
        end
        chk("finish event", 8'h01, {7'h00, i < 4000});
        chk("byte count", 8'(n * reps), 8'(u_mod.seen.size()));
        for (i = 0; i < n * reps; i++) chk("byte", pat[first + i % n], u_mod.seen[i]);
    endtask
    task end_sim;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        end_sim;
    end
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        cfg.length_field_en <= 1'b1;
        cfg.pin_func_sel <= {3'h0, 3'h0, 3'h5};
        pulse(0);
        pulse(1);
        foreach (pat[k]) write_byte(pat[k]);
        cfg.tx_length <= 8'h04;
        send(0, 4, 1, 0);
        send(0, 4, 1, 0);
        chk("length field", 8'h04, length_field);
        cfg.fifo_mode <= `MODE_BLOCK;
        cfg.tx_start_addr <= 6'h02;
        cfg.tx_length <= 8'h02;
        send(2, 2, 1, 0);
        cfg.fifo_mode <= `MODE_SIMPLE;
        cfg.tx_start_addr <= 6'h00;
        cfg.tx_length <= 8'h04;
        cfg.resend_ack_en <= 1'b1;
        cfg.resend_limit <= 4'h1;
        send(0, 4, 3, 1);
        chk("resend count", 8'h02, {3'h0, resend_count});
        pulse(4);
        repeat (2) @(posedge clock);
        end_sim;
    end
endmodule
`default_nettype wire
